// ### verilog/adcs_ctrl.sv
// Sequencing, trigger, register and interrupt control of the converter
`timescale 1ns/100ps
`include "adcs_regs.svh"
module adcs_ctrl #(
	parameter int STAGES = `ADCS_STAGES
) (
	input  wire logic                                   ref_clk,
	input  wire logic                                   rst,
	input  wire adcs_pkg::adcs_bus_req_type             bus,
	output logic [`ADCS_DW-1:0]                         rd_data,
	input  wire logic                                   event_manager_a,
	input  wire logic                                   event_manager_b,
	input  wire logic                                   external_conversion_start,
	input  wire logic [`ADCS_CH_N-1:0][`ADCS_RES_W-1:0] channel_data,
	output logic                                        sample_hold,
	output logic                                        converter_clock,
	output adcs_pkg::adcs_power_type                    power,
	output logic                                        busy,
	output logic                                        irq
);
	import adcs_pkg::*;

	typedef struct packed {
		logic [2:0]               pin_sync;
		logic                     pin_level;
		logic [3:0]               hdiv;
		logic                     cclk;
		logic                     run;
		logic                     mode;
		logic [3:0]               acq;
		logic [3:0]               chsel;
		adcs_power_type           power;
		logic [3:0]               div;
		logic [1:0]               flag;
		logic [1:0]               mask;
		logic [`ADCS_IRQ_LAG-1:0] lag_a;
		logic [`ADCS_IRQ_LAG-1:0] lag_b;
		adcs_seq_type             seq;
		logic [5:0]               cnt;
		logic                     sh;
		logic [3:0]               acq_l;
		logic                     mode_l;
		logic [`ADCS_RES_W-1:0]   res_a;
		logic [`ADCS_RES_W-1:0]   res_b;
		logic [`ADCS_DW-1:0]      rd_data;
	} adcs_ctrl_st_type;

	adcs_ctrl_st_type s;
	adcs_ctrl_st_type next_s;

	logic [3:0]             div_lim;
	logic                   ht;
	logic                   pin_rise;
	logic                   sw_start;
	logic                   powered;
	logic                   trig;
	logic                   fall;
	logic                   push_b;
	logic [3:0]             idx_a;
	logic [`ADCS_RES_W-1:0] sample_a;
	logic [`ADCS_RES_W-1:0] sample_b;
	logic [5:0]             sh_last;
	logic [5:0]             gap_last;
	logic [1:0]             flag_clr;
	adcs_slot_type          out;
	logic                   wr_a;
	logic                   wr_b;

	// half period never below one cycle
	assign div_lim = (s.div == 4'h0) ? 4'h0 : s.div - 4'h1;
	assign ht = (s.hdiv >= div_lim);
	// Only the second and third stages are compared
	assign pin_rise = (s.pin_sync[1] == s.pin_sync[2]) && s.pin_sync[2] && !s.pin_level;
	assign sw_start = bus.wr && (bus.addr == `ADCS_OFS_CTRL_TWO)
		&& bus.wdata[`ADCS_BIT_START];
	assign powered = &s.power;
	// any of the four sources starts, only while all power bits are on
	assign trig = (event_manager_a || event_manager_b || sw_start || pin_rise) && powered;
	assign fall = ht && (s.seq == ADCS_SAMPLE) && (s.cnt == 6'h00);
	// paired conversion only in mode one
	assign push_b = fall && s.mode_l;
	assign idx_a = s.mode_l ? {1'b0, s.chsel[2:0]} : s.chsel;
	assign sample_a = channel_data[idx_a];
	assign sample_b = channel_data[{1'b1, s.chsel[2:0]}];
	assign sh_last = {1'b0, s.acq_l, 1'b1};
	assign gap_last = (s.mode_l ? `ADCS_HT_GAP_SIM : `ADCS_HT_GAP_SEQ) - 6'h01;
	assign flag_clr = (bus.wr && bus.addr == `ADCS_OFS_STATUS)
		? bus.wdata[`ADCS_FLAG_HI:`ADCS_FLAG_LO] : 2'h0;
	assign wr_a = out.valid && !out.pair_b;
	assign wr_b = out.valid && out.pair_b;

	adcs_pipe #(
		.STAGES (STAGES)
	) u_pipe (
		.ref_clk   (ref_clk),
		.rst       (rst),
		.half_tick (ht),
		.push_a    (fall),
		.push_b    (push_b),
		.data_a    (sample_a),
		.data_b    (sample_b),
		.result    (out)
	);

	always_comb begin
		next_s = s;
		next_s.pin_sync = {s.pin_sync[1:0], external_conversion_start};
		if (s.pin_sync[1] == s.pin_sync[2]) begin
			next_s.pin_level = s.pin_sync[2];
		end
		next_s.hdiv = ht ? 4'h0 : s.hdiv + 4'h1;
		if (ht) begin
			next_s.cclk = !s.cclk;
		end

		if (bus.wr) begin
			if (bus.addr == `ADCS_OFS_CTRL_ONE) begin
				next_s.run = bus.wdata[`ADCS_BIT_RUN];
				next_s.mode = bus.wdata[`ADCS_BIT_MODE];
				next_s.acq = bus.wdata[`ADCS_ACQ_HI:`ADCS_ACQ_LO];
			end else if (bus.addr == `ADCS_OFS_CTRL_TWO) begin
				next_s.chsel = bus.wdata[`ADCS_CHSEL_HI:`ADCS_CHSEL_LO];
			end else if (bus.addr == `ADCS_OFS_CTRL_THREE) begin
				// all power bits in one write
				next_s.power = '{bandgap_power_on: bus.wdata[`ADCS_BIT_BANDGAP],
					reference_power_on: bus.wdata[`ADCS_BIT_REFERENCE],
					core_power_on: bus.wdata[`ADCS_BIT_CORE]};
				next_s.div = bus.wdata[`ADCS_DIV_HI:`ADCS_DIV_LO];
			end else if (bus.addr == `ADCS_OFS_MASK) begin
				next_s.mask = bus.wdata[`ADCS_FLAG_HI:`ADCS_FLAG_LO];
			end
		end

		case (s.seq)
			ADCS_IDLE: begin
				if (trig) begin
					next_s.seq = ADCS_DELAY;
					next_s.cnt = `ADCS_HT_DELAY - 6'h01;
					next_s.acq_l = s.acq;
					next_s.mode_l = s.mode;
				end
			end
			ADCS_DELAY, ADCS_GAP: begin
				if (ht) begin
					if (s.cnt == 6'h00) begin
						next_s.seq = ADCS_SAMPLE;
						next_s.sh = 1'b1;
						next_s.cnt = sh_last;
					end else begin
						next_s.cnt = s.cnt - 6'h01;
					end
				end
			end
			ADCS_SAMPLE: begin
				if (ht) begin
					if (s.cnt == 6'h00) begin
						next_s.sh = 1'b0;
						// continuous run restarts after one gap
						if (s.run) begin
							next_s.seq = ADCS_GAP;
							next_s.cnt = gap_last;
						end else begin
							next_s.seq = ADCS_IDLE;
						end
					end else begin
						next_s.cnt = s.cnt - 6'h01;
					end
				end
			end
			default: begin
				next_s.seq = ADCS_IDLE;
				next_s.sh = 1'b0;
			end
		endcase

		// any power bit dropped aborts sampling
		if (!(&next_s.power)) begin
			next_s.seq = ADCS_IDLE;
			next_s.sh = 1'b0;
		end

		// results change only on a write
		if (wr_a) begin
			next_s.res_a = out.data;
		end
		if (wr_b) begin
			next_s.res_b = out.data;
		end

		next_s.lag_a = {s.lag_a[`ADCS_IRQ_LAG-2:0], wr_a};
		next_s.lag_b = {s.lag_b[`ADCS_IRQ_LAG-2:0], wr_b};
		// Set beats a same-cycle clear
		next_s.flag = (s.flag & ~flag_clr)
			| {s.lag_b[`ADCS_IRQ_LAG-1], s.lag_a[`ADCS_IRQ_LAG-1]};

		// Unmapped and idle reads return zero
		next_s.rd_data = '0;
		if (bus.rd) begin
			if (bus.addr == `ADCS_OFS_CTRL_ONE) begin
				next_s.rd_data[`ADCS_BIT_RUN] = s.run;
				next_s.rd_data[`ADCS_BIT_MODE] = s.mode;
				next_s.rd_data[`ADCS_ACQ_HI:`ADCS_ACQ_LO] = s.acq;
			end else if (bus.addr == `ADCS_OFS_CTRL_TWO) begin
				next_s.rd_data[`ADCS_CHSEL_HI:`ADCS_CHSEL_LO] = s.chsel;
			end else if (bus.addr == `ADCS_OFS_CTRL_THREE) begin
				next_s.rd_data[`ADCS_BIT_BANDGAP] = s.power.bandgap_power_on;
				next_s.rd_data[`ADCS_BIT_REFERENCE] = s.power.reference_power_on;
				next_s.rd_data[`ADCS_BIT_CORE] = s.power.core_power_on;
				next_s.rd_data[`ADCS_DIV_HI:`ADCS_DIV_LO] = s.div;
			end else if (bus.addr == `ADCS_OFS_STATUS) begin
				next_s.rd_data[`ADCS_FLAG_HI:`ADCS_FLAG_LO] = s.flag;
				next_s.rd_data[`ADCS_BIT_BUSY] = (s.seq != ADCS_IDLE);
			end else if (bus.addr == `ADCS_OFS_MASK) begin
				next_s.rd_data[`ADCS_FLAG_HI:`ADCS_FLAG_LO] = s.mask;
			end else if (bus.addr == `ADCS_OFS_RESULT_A) begin
				next_s.rd_data[`ADCS_RES_W-1:0] = s.res_a;
			end else if (bus.addr == `ADCS_OFS_RESULT_B) begin
				next_s.rd_data[`ADCS_RES_W-1:0] = s.res_b;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.seq <= ADCS_IDLE;
			s.div <= `ADCS_RST_DIV;
		end else begin
			s <= next_s;
		end
	end

	assign rd_data = s.rd_data;
	assign sample_hold = s.sh;
	assign converter_clock = s.cclk;
	assign power = s.power;
	assign busy = (s.seq != ADCS_IDLE);
	assign irq = |(s.flag & s.mask);

	// Helper counters watched only by the checks below
	logic [3:0] lat;
	logic       lat_pair;
	logic [5:0] since_fall;
	logic       chain;
	logic [5:0] sh_hts;
	logic [2:0] dly_hts;

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			lat <= 4'hf;
			lat_pair <= 1'b0;
			since_fall <= 6'h3f;
			chain <= 1'b0;
			sh_hts <= 6'h00;
			dly_hts <= 3'h0;
		end else begin
			if (fall) begin
				lat <= 4'h0;
				lat_pair <= s.mode_l;
				since_fall <= 6'h00;
			end else if (ht) begin
				lat <= (lat == 4'hf) ? lat : lat + 4'h1;
				since_fall <= (since_fall == 6'h3f) ? since_fall : since_fall + 6'h01;
			end
			chain <= (s.seq == ADCS_GAP) || (chain && s.seq == ADCS_SAMPLE);
			sh_hts <= !s.sh ? 6'h00 : (ht ? sh_hts + 6'h01 : sh_hts);
			dly_hts <= (s.seq != ADCS_DELAY) ? 3'h0 : (ht ? dly_hts + 3'h1 : dly_hts);
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	sequence delay_to_sample;
		$rose(sample_hold) ##0 $past(s.seq == ADCS_DELAY);
	endsequence

	sequence ctrl_three_all_off;
		bus.wr && bus.addr == `ADCS_OFS_CTRL_THREE
			&& bus.wdata[`ADCS_BIT_CORE:`ADCS_BIT_REFERENCE] == 3'h0;
	endsequence

	power_clear_a: assert property (ctrl_three_all_off |=>
		(power == '0) && !busy && !sample_hold)
		else $error("power bits not cleared together");
	mode_pair_a: assert property (ht && lat == 4'h9 && !lat_pair |-> !wr_b)
		else $error("single mode produced a second result");
	trig_start_a: assert property (s.seq == ADCS_IDLE && trig |=>
		busy && s.seq == ADCS_DELAY && !sample_hold)
		else $error("accepted trigger did not start sequence");
	capture_edge_a: assert property (fall |=> $fell(sample_hold))
		else $error("capture not at falling edge");
	sh_width_a: assert property (fall |-> sh_hts == sh_last)
		else $error("sample pulse width wrong");
	start_delay_a: assert property (delay_to_sample |->
		$past(dly_hts) == 3'h4)
		else $error("sampling not 2.5 clocks after trigger");
	first_result_a: assert property (ht && lat == 4'h7 |-> wr_a)
		else $error("result A not four clocks after sample");
	spacing_a: assert property (fall && chain && !s.mode_l |->
		since_fall == sh_last + 6'h02)
		else $error("sequential result spacing wrong");
	flag_lag_a: assert property (wr_a |-> ##3 s.flag[0])
		else $error("flag not set after result update");
	pair_result_a: assert property (ht && lat == 4'h9 && lat_pair |-> wr_b)
		else $error("paired sample gave no second result");
	hold_a: assert property (!wr_a |=> $stable(s.res_a))
		else $error("result A changed without a result");
endmodule

// ### verilog/adcs_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH

`define ADCS_AW 4
`define ADCS_DW 16
`define ADCS_RES_W 12
`define ADCS_CH_N 16
`define ADCS_STAGES 4

`define ADCS_OFS_CTRL_ONE 4'h0
`define ADCS_OFS_CTRL_TWO 4'h1
`define ADCS_OFS_CTRL_THREE 4'h2
`define ADCS_OFS_STATUS 4'h3
`define ADCS_OFS_MASK 4'h4
`define ADCS_OFS_RESULT_A 4'h5
`define ADCS_OFS_RESULT_B 4'h6

`define ADCS_BIT_RUN 0
`define ADCS_BIT_MODE 4
`define ADCS_ACQ_LO 8
`define ADCS_ACQ_HI 11
`define ADCS_BIT_START 0
`define ADCS_CHSEL_LO 4
`define ADCS_CHSEL_HI 7
`define ADCS_BIT_CORE 7
`define ADCS_BIT_BANDGAP 6
`define ADCS_BIT_REFERENCE 5
`define ADCS_DIV_LO 0
`define ADCS_DIV_HI 3
`define ADCS_FLAG_LO 0
`define ADCS_FLAG_HI 1
`define ADCS_BIT_BUSY 4

`define ADCS_RST_DIV 4'h2

// Counts in converter half periods, interrupt lag in clock cycles
`define ADCS_HT_DELAY 6'h05
`define ADCS_HT_GAP_SEQ 6'h02
`define ADCS_HT_GAP_SIM 6'h04
`define ADCS_IRQ_LAG 2

`endif

// ### verilog/adcs_pkg.sv
// Shared types of the converter sequencing block
`include "adcs_regs.svh"
package adcs_pkg;

	typedef struct packed {
		logic [`ADCS_AW-1:0] addr;
		logic [`ADCS_DW-1:0] wdata;
		logic                wr;
		logic                rd;
	} adcs_bus_req_type;

	typedef enum logic [3:0] {
		ADCS_IDLE   = 4'h1,
		ADCS_DELAY  = 4'h2,
		ADCS_SAMPLE = 4'h4,
		ADCS_GAP    = 4'h8
	} adcs_seq_type;

	typedef struct packed {
		logic                   valid;
		logic                   pair_b;
		logic [`ADCS_RES_W-1:0] data;
	} adcs_slot_type;

	typedef struct packed {
		logic bandgap_power_on;
		logic reference_power_on;
		logic core_power_on;
	} adcs_power_type;

endpackage

// ### verilog/adcs_pipe.sv
// Four-stage conversion pipeline stepped on converter half periods
`timescale 1ns/100ps
`include "adcs_regs.svh"
module adcs_pipe #(
	parameter int STAGES = `ADCS_STAGES
) (
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	input  wire logic                   half_tick,
	input  wire logic                   push_a,
	input  wire logic                   push_b,
	input  wire logic [`ADCS_RES_W-1:0] data_a,
	input  wire logic [`ADCS_RES_W-1:0] data_b,
	output adcs_pkg::adcs_slot_type     result
);
	import adcs_pkg::*;

	// B rides two half periods behind A, one converter clock later
	localparam int SLOTS   = 2 * STAGES + 2;
	localparam int ENTRY_A = 2;

	typedef struct packed {
		adcs_slot_type [SLOTS-1:0] slot;
	} adcs_pipe_st_type;

	adcs_pipe_st_type s;
	adcs_pipe_st_type next_s;

	always_comb begin
		next_s = s;
		if (half_tick) begin
			for (int i = SLOTS - 1; i > 0; i--) begin
				next_s.slot[i] = s.slot[i - 1];
			end
			next_s.slot[0] = '{valid: push_b, pair_b: 1'b1, data: data_b};
			if (push_a) begin
				next_s.slot[ENTRY_A] = '{valid: 1'b1, pair_b: 1'b0, data: data_a};
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign result = '{valid: half_tick && s.slot[SLOTS-1].valid,
		pair_b: s.slot[SLOTS-1].pair_b, data: s.slot[SLOTS-1].data};

	slot_free_a: assert property (@(posedge ref_clk) disable iff (rst)
		half_tick && push_a |-> !s.slot[ENTRY_A-1].valid)
		else $error("pipeline entry collides with older sample");

endmodule

// ### verilog/adcs_ctrl_fix.sv
// Spare file, holds no logic

// ### verification/adcs_analog_model.sv
// Analog input model: each channel shows its own 12-bit code
`timescale 1ns/100ps
`include "adcs_regs.svh"
module adcs_analog_model (
	input  wire logic [7:0]                        level,
	output logic [`ADCS_CH_N-1:0][`ADCS_RES_W-1:0] channel_data
);
	// Channel number in the low nibble so a wrong mux choice shows
	always_comb begin
		for (int i = 0; i < `ADCS_CH_N; i++) begin
			channel_data[i] = {level, i[3:0]};
		end
	end
endmodule

// ### verification/adcs_ctrl_test.sv
// Self-checking bench of the converter sequencing block
`timescale 1ns/100ps
`include "adcs_regs.svh"
module adcs_ctrl_test;
	import adcs_pkg::*;
	logic                                   ref_clk;
	logic                                   rst;
	adcs_bus_req_type                       bus;
	logic [`ADCS_DW-1:0]                    rd_data;
	logic                                   event_manager_a;
	logic                                   event_manager_b;
	logic                                   external_conversion_start;
	logic [`ADCS_CH_N-1:0][`ADCS_RES_W-1:0] channel_data;
	logic                                   sample_hold;
	logic                                   converter_clock;
	adcs_power_type                         power;
	logic                                   busy;
	logic                                   irq;
	logic [7:0]                             level;
	logic [15:0]                            v;
	int                                     n_errors;
	int                                     n_tests;
	int                                     n;

	adcs_ctrl adcs_ctrl_inst (
		.ref_clk(ref_clk),
		.rst(rst),
		.bus(bus),
		.rd_data(rd_data),
		.event_manager_a(event_manager_a),
		.event_manager_b(event_manager_b),
		.external_conversion_start(external_conversion_start),
		.channel_data(channel_data),
		.sample_hold(sample_hold),
		.converter_clock(converter_clock),
		.power(power),
		.busy(busy),
		.irq(irq)
	);

	adcs_analog_model adcs_analog_model_inst (
		.level(level),
		.channel_data(channel_data)
	);

	task automatic results;
		$display("Checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] dat);
		@(posedge ref_clk);
		bus.addr <= a;
		bus.wdata <= dat;
		bus.wr <= 1'b1;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
		#1;
	endtask

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] dat);
		@(posedge ref_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1;
		dat = rd_data;
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask

	// Counts cycles until the chosen output reaches lvl
	task automatic till(input int sel, input logic lvl, output int c);
		c = 0;
		while (((sel == 0) ? sample_hold : (sel == 1) ? irq : converter_clock) !== lvl
			&& c < 500) begin
			tick(1);
			c++;
		end
	endtask

	task automatic fire(input int src, input logic [3:0] ch);
		if (src == 3) begin
			wr_reg(`ADCS_OFS_CTRL_TWO, {8'h00, ch, 4'h1});
		end else begin
			@(posedge ref_clk);
			case (src)
				0: event_manager_a <= 1'b1;
				1: event_manager_b <= 1'b1;
				default: external_conversion_start <= 1'b1;
			endcase
			// Pin must outlast the filter until two stages agree
			repeat ((src == 2) ? 3 : 1) @(posedge ref_clk);
			event_manager_a <= 1'b0;
			event_manager_b <= 1'b0;
			external_conversion_start <= 1'b0;
			#1;
		end
	endtask

	// One single-shot conversion timed from the trigger cycle
	task automatic meas(input logic [3:0] acq);
		int d;
		int w;
		int t;
		wr_reg(`ADCS_OFS_CTRL_ONE, {4'h0, acq, 8'h00});
		fire(0, 4'h0);
		till(0, 1'b1, d);
		check("start delay", 16'(d), 16'd5);
		till(0, 1'b0, w);
		check("pulse width", 16'(w), 16'(2 * (1 + acq)));
		till(1, 1'b1, t);
		check("irq delay", 16'(d + w + t), 16'(17 + 2 * acq));
		wr_reg(`ADCS_OFS_STATUS, 16'h0003);
	endtask

	task automatic period(output int p);
		int a;
		int b;
		till(0, 1'b1, a);
		till(0, 1'b0, a);
		till(0, 1'b1, b);
		p = a + b;
	endtask

	task automatic power_cycle(input logic [15:0] ctrl_one);
		wr_reg(`ADCS_OFS_CTRL_THREE, 16'h0001);
		tick(1);
		check("power off", {13'h0, power}, 16'h0000);
		check("busy abort", {15'h0, busy}, 16'h0000);
		wr_reg(`ADCS_OFS_CTRL_ONE, ctrl_one);
		wr_reg(`ADCS_OFS_CTRL_THREE, 16'h00e1);
		// Results still in the pipeline land before the flags are cleared
		tick(20);
		wr_reg(`ADCS_OFS_STATUS, 16'h0003);
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		results();
	end

	initial begin
		bus = '0;
		event_manager_a = 1'b0;
		event_manager_b = 1'b0;
		external_conversion_start = 1'b0;
		level = 8'h5a;
		n_errors = 0;
		n_tests = 0;
		rst = 1'b1;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		rd_reg(`ADCS_OFS_CTRL_THREE, v);
		check("divider reset", v, 16'h0002);
		till(2, 1'b1, n);
		till(2, 1'b0, n);
		check("clock half", 16'(n), 16'd2);
		rd_reg(4'hf, v);
		check("unmapped", v, 16'h0000);
		fire(0, 4'h0);
		tick(10);
		check("start unpowered", {15'h0, busy}, 16'h0000);
		wr_reg(`ADCS_OFS_CTRL_THREE, 16'h0061);
		tick(1);
		check("ref first", {13'h0, power}, 16'h0006);
		wr_reg(`ADCS_OFS_CTRL_THREE, 16'h00e1);
		tick(1);
		check("core on", {13'h0, power}, 16'h0007);
		for (int s = 0; s < 4; s++) begin
			wr_reg(`ADCS_OFS_CTRL_TWO, {8'h00, 4'(s * 5), 4'h0});
			fire(s, 4'(s * 5));
			tick(60);
			rd_reg(`ADCS_OFS_RESULT_A, v);
			check("result", v, {4'h0, level, 4'(s * 5)});
			if (s == 0) begin
				rd_reg(`ADCS_OFS_STATUS, v);
				check("flag", v & 16'h0003, 16'h0001);
				check("irq masked", {15'h0, irq}, 16'h0000);
				wr_reg(`ADCS_OFS_MASK, 16'h0003);
				tick(1);
				check("irq on", {15'h0, irq}, 16'h0001);
			end
			wr_reg(`ADCS_OFS_STATUS, 16'h0003);
			tick(1);
			check("irq clear", {15'h0, irq}, 16'h0000);
		end
		level <= 8'ha5;
		rd_reg(`ADCS_OFS_RESULT_A, v);
		check("result hold", v, 16'h05af);
		meas(4'h0);
		meas(4'hf);
		wr_reg(`ADCS_OFS_CTRL_ONE, 16'h0301);
		fire(0, 4'h0);
		period(n);
		check("single spacing", 16'(n), 16'd10);
		power_cycle(16'h0311);
		fire(0, 4'h0);
		period(n);
		check("paired spacing", 16'(n), 16'd12);
		power_cycle(16'h0010);
		wr_reg(`ADCS_OFS_CTRL_TWO, 16'h0030);
		fire(1, 4'h3);
		till(1, 1'b1, n);
		tick(5);
		rd_reg(`ADCS_OFS_STATUS, v);
		check("pair flags", v & 16'h0003, 16'h0003);
		rd_reg(`ADCS_OFS_RESULT_A, v);
		check("pair a", v, 16'h0a53);
		rd_reg(`ADCS_OFS_RESULT_B, v);
		check("pair b", v, 16'h0a5b);
		results();
	end
endmodule
